// ---- dns_map.svh ----
// Purpose: Constants for the network status display and mode configuration block
// Assumes: 50 MHz sys_clk, synchronous active-high reset
// Notes: All offsets, codes and counts used by the logic are named here
//
// How it works
// - With no error pending and the host controller running the display shows the node address, 0 to 63.
// - While the host controller is stopped and no error is pending the display shows code 80.
// - A duplicate or out-of-range node identifier shows code F0.
// - An empty polled-node table shows code F1.
// - Low working supply voltage shows code F2.
// - The test switch enters test mode with code F3, left only after switch off and power cycle.
// - Bus-off shows F4, missing network power F5, internal memory fault F6.
// - As a slave the default input and output sizes are both 8 bytes.
// - As a slave configured sizes up to 200 bytes are accepted and larger ones rejected.
// - Standard baud mode offers exactly 125k, 250k and 500k bit/s.
// - Extended baud mode offers 10k, 20k, 50k, 125k, 250k, 500k, 800k and 1M bit/s.
// - The role comes from downloaded configuration and takes effect only at next power-on.
// - An extended rate applies only with enable stored, both switches on and a power cycle.
`ifndef DNS_MAP_SVH
`define DNS_MAP_SVH

// ----------------------------------------
// Display codes
// ----------------------------------------
`define DNS_CODE_STOP 8'h80
`define DNS_CODE_NODE 8'hF0
`define DNS_CODE_SCAN 8'hF1
`define DNS_CODE_LOWV 8'hF2
`define DNS_CODE_TEST 8'hF3
`define DNS_CODE_BOFF 8'hF4
`define DNS_CODE_NPWR 8'hF5
`define DNS_CODE_MEM 8'hF6
`define DNS_NODE_MAX 8'h3F

// ----------------------------------------
// Data sizes and baud
// ----------------------------------------
`define DNS_SIZE_DEFAULT 8'h08
`define DNS_SIZE_MAX 8'hC8
`define DNS_BAUD_STD_COUNT 3'h3
`define DNS_BAUD_DEFAULT 3'h3
`define DNS_CLK_HZ 50000000

`endif

// ---- dns_pkg.sv ----
// Purpose: Types for the network status display and mode configuration block
// Assumes: dns_map.svh holds the numeric constants
// Notes: Baud indexes are shared by both modes
package dns_pkg;

   // Baud index: 0..7 maps to the extended list in order
   typedef enum logic [2:0] {
      DNS_B10K = 3'h0,
      DNS_B20K = 3'h1,
      DNS_B50K = 3'h2,
      DNS_B125K = 3'h3,
      DNS_B250K = 3'h4,
      DNS_B500K = 3'h5,
      DNS_B800K = 3'h6,
      DNS_B1M = 3'h7
   } dns_baud_t;

   typedef enum logic [1:0] {
      DNS_BOOT = 2'b00,
      DNS_RUN = 2'b01,
      DNS_TEST = 2'b11
   } dns_state_t;

   // Error and status inputs from the network side
   typedef struct packed {
      logic nodeIdFault;
      logic scanListEmpty;
      logic lowVoltage;
      logic busOff;
      logic noNetPower;
      logic memFault;
   } dns_err_t;

   // Configuration as stored by a download
   typedef struct packed {
      logic masterMode;
      logic extBaudEnable;
      dns_baud_t baudSel;
      logic [7:0] inSize;
      logic [7:0] outSize;
   } dns_cfg_t;

endpackage

// ---- dns_display_mux.sv ----
// Purpose: Picks the two-digit display code from address and error flags
// Assumes: Error flags are levels, synchronous to sys_clk
// Notes: Highest code wins when several errors stand together
`timescale 1ns/100ps
`include "dns_map.svh"
module dns_display_mux (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clkEn,
   // Status
   input wire dns_pkg::dns_err_t errIn,
   input wire logic testMode,
   input wire logic plcStopped,
   input wire logic [5:0] nodeAddr,
   // Display
   output logic [7:0] dispCode,
   output logic errActive
);
   import dns_pkg::*;

   logic [7:0] code_d;
   logic [7:0] code_q;
   wire anyErr = |errIn | testMode;

   // Fixed priority so the most severe fault is the one seen
   always_comb begin
      code_d = {2'b00, nodeAddr};
      if (errIn.memFault) code_d = `DNS_CODE_MEM;
      else if (errIn.noNetPower) code_d = `DNS_CODE_NPWR;
      else if (errIn.busOff) code_d = `DNS_CODE_BOFF;
      else if (testMode) code_d = `DNS_CODE_TEST;
      else if (errIn.lowVoltage) code_d = `DNS_CODE_LOWV;
      else if (errIn.scanListEmpty) code_d = `DNS_CODE_SCAN;
      else if (errIn.nodeIdFault) code_d = `DNS_CODE_NODE;
      else if (plcStopped) code_d = `DNS_CODE_STOP;
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         code_q <= 8'h00;
      end else if (clkEn) begin
         code_q <= code_d;
      end
   end

   assign dispCode = code_q;
   assign errActive = anyErr;

   a_err_shows: assert property (@(posedge sys_clk) disable iff (sys_rst)
      clkEn && anyErr |=> dispCode[7:4] == 4'hF)
      else $error("error active but display not an F code");
   a_addr_shows: assert property (@(posedge sys_clk) disable iff (sys_rst)
      clkEn && !anyErr && !plcStopped |=> dispCode == {2'b00, $past(nodeAddr)})
      else $error("node address not shown");
   a_stop_shows: assert property (@(posedge sys_clk) disable iff (sys_rst)
      clkEn && !anyErr && plcStopped |=> dispCode == `DNS_CODE_STOP)
      else $error("stop code not shown");
   a_busoff_code: assert property (@(posedge sys_clk) disable iff (sys_rst)
      clkEn && errIn.busOff && !errIn.memFault && !errIn.noNetPower
      |=> dispCode == `DNS_CODE_BOFF)
      else $error("bus-off code not shown");
   a_test_shows: assert property (@(posedge sys_clk) disable iff (sys_rst)
      clkEn && testMode && !errIn.busOff && !errIn.memFault && !errIn.noNetPower
      |=> dispCode == `DNS_CODE_TEST)
      else $error("test code not shown");

endmodule // dns_display_mux

// ---- dns_status_config.sv ----
// Purpose: Status display and role/baud/size configuration of a network module
// Assumes: Power-on is sys_rst; switches are synchronous to sys_clk
// Notes: Stored configuration is copied to the active outputs only at power-on
`timescale 1ns/100ps
`include "dns_map.svh"
module dns_status_config #(
   parameter logic [7:0] SIZE_DEFAULT = `DNS_SIZE_DEFAULT,
   parameter logic [7:0] SIZE_MAX = `DNS_SIZE_MAX
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clkEn,
   // Operator switches
   input wire logic testFunctionSwitch,
   input wire logic baudSelectSwitchLow,
   input wire logic baudSelectSwitchHigh,
   // Network and host status
   input wire dns_pkg::dns_err_t errIn,
   input wire logic plcStopped,
   input wire logic [5:0] nodeAddr,
   // Configuration download
   input wire logic cfgWrite,
   input wire dns_pkg::dns_cfg_t cfgIn,
   output logic cfgReject,
   // Display
   output logic [7:0] dispCode,
   output logic errActive,
   // Active configuration
   output logic masterActive,
   output dns_pkg::dns_baud_t baudActive,
   output logic extBaudActive,
   output logic [7:0] inSizeActive,
   output logic [7:0] outSizeActive,
   output logic testActive
);
   import dns_pkg::*;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic sizeOk(input logic [7:0] sz);
      sizeOk = (sz <= SIZE_MAX);
   endfunction

   // Standard list holds only the three middle rates
   function automatic logic stdRate(input dns_baud_t b);
      stdRate = (b == DNS_B125K) || (b == DNS_B250K) || (b == DNS_B500K);
   endfunction

   // ----------------------------------------
   // Stored configuration (non-volatile image)
   // ----------------------------------------
   dns_cfg_t stored_q;
   dns_cfg_t stored_d;
   dns_cfg_t active_q;
   dns_cfg_t active_d;
   dns_state_t state_q;
   dns_state_t state_d;
   logic reject_q;
   logic reject_d;
   logic extBaud_q;
   logic extBaud_d;

   // Slave sizes beyond the limit refuse the whole download
   wire sizesOk = sizeOk(cfgIn.inSize) && sizeOk(cfgIn.outSize);
   wire takeCfg = cfgWrite && (state_q != DNS_BOOT);
   wire switchesOn = baudSelectSwitchLow && baudSelectSwitchHigh;
   // All three conditions, sampled at the boot step that follows power-on
   wire extQualify = stored_q.extBaudEnable && switchesOn;

   // ----------------------------------------
   // Power-on sequence
   // ----------------------------------------
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         DNS_BOOT: state_d = testFunctionSwitch ? DNS_TEST : DNS_RUN;
         DNS_RUN: state_d = testFunctionSwitch ? DNS_TEST : DNS_RUN;
         // Only a reset leaves test mode, even with the switch back off
         DNS_TEST: state_d = DNS_TEST;
         default: state_d = DNS_BOOT;
      endcase
   end

   always_comb begin
      stored_d = stored_q;
      reject_d = 1'b0;
      if (takeCfg && sizesOk) begin
         stored_d = cfgIn;
      end
      if (takeCfg && !sizesOk) begin
         reject_d = 1'b1;
      end
   end

   // Downloaded role, rate and sizes are copied out only during boot
   always_comb begin
      active_d = active_q;
      extBaud_d = extBaud_q;
      if (state_q == DNS_BOOT) begin
         active_d = stored_q;
         extBaud_d = extQualify;
         if (!extQualify && !stdRate(stored_q.baudSel)) begin
            active_d.baudSel = DNS_B125K;
         end
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   // Stored image survives resets here; a real part keeps it in flash
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state_q <= DNS_BOOT;
         active_q <= '0;
         extBaud_q <= 1'b0;
         reject_q <= 1'b0;
      end else if (clkEn) begin
         state_q <= state_d;
         active_q <= active_d;
         extBaud_q <= extBaud_d;
         reject_q <= reject_d;
      end
   end

   // Blank-image flag starts clear and is never reset, so only the first
   // power-on loads defaults; later resets keep the downloaded image
   logic imageValid_q = 1'b0;
   wire loadDefaults = sys_rst && !imageValid_q;
   always_ff @(posedge sys_clk) begin
      if (clkEn && loadDefaults) begin
         imageValid_q <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (clkEn) begin
         if (loadDefaults) begin
            stored_q <= {1'b0, 1'b0, DNS_B125K, SIZE_DEFAULT, SIZE_DEFAULT};
         end else if (!sys_rst) begin
            stored_q <= stored_d;
         end
      end
   end

   // ----------------------------------------
   // Display
   // ----------------------------------------
   dns_display_mux u_disp (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .clkEn(clkEn),
      .errIn(errIn),
      .testMode(state_q == DNS_TEST),
      .plcStopped(plcStopped),
      .nodeAddr(nodeAddr),
      .dispCode(dispCode),
      .errActive(errActive)
   );

   assign cfgReject = reject_q;
   assign masterActive = active_q.masterMode;
   assign baudActive = active_q.baudSel;
   assign extBaudActive = extBaud_q;
   assign inSizeActive = active_q.inSize;
   assign outSizeActive = active_q.outSize;
   assign testActive = (state_q == DNS_TEST);

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_test_sticky: assert property (@(posedge sys_clk) disable iff (sys_rst)
      state_q == DNS_TEST |=> state_q == DNS_TEST)
      else $error("test mode left without reset");
   a_role_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
      state_q != DNS_BOOT |=> $stable(masterActive))
      else $error("role changed outside power-on");
   a_size_reject: assert property (@(posedge sys_clk) disable iff (sys_rst)
      clkEn && takeCfg && !sizesOk |=> cfgReject && $stable(stored_q))
      else $error("oversize config not rejected");
   a_std_rate: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !extBaudActive && state_q != DNS_BOOT |-> stdRate(baudActive))
      else $error("non-standard rate in standard mode");
   a_ext_needs: assert property (@(posedge sys_clk) disable iff (sys_rst)
      clkEn && state_q == DNS_BOOT && !switchesOn |=> !extBaudActive)
      else $error("extended rate without switches");
   a_size_limit: assert property (@(posedge sys_clk) disable iff (sys_rst)
      state_q != DNS_BOOT |-> inSizeActive <= SIZE_MAX && outSizeActive <= SIZE_MAX)
      else $error("active size above limit");
   a_blank_defaults: assert property (@(posedge sys_clk)
      clkEn && loadDefaults
      |=> stored_q.inSize == SIZE_DEFAULT && stored_q.outSize == SIZE_DEFAULT)
      else $error("blank image did not load default sizes");
   a_boot_once: assert property (@(posedge sys_clk) disable iff (sys_rst)
      state_q != DNS_BOOT |=> state_q != DNS_BOOT)
      else $error("boot step repeated without reset");
   a_cfg_stored: assert property (@(posedge sys_clk) disable iff (sys_rst)
      clkEn && takeCfg && sizesOk |=> stored_q == $past(cfgIn))
      else $error("accepted download not stored");
   a_cfg_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
      state_q != DNS_BOOT
      |=> $stable(baudActive) && $stable(extBaudActive)
          && $stable(inSizeActive) && $stable(outSizeActive))
      else $error("active setting changed outside power-on");
   a_reject_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
      clkEn && !(takeCfg && !sizesOk) |=> !cfgReject)
      else $error("reject without oversize download");
   a_ext_enable: assert property (@(posedge sys_clk) disable iff (sys_rst)
      clkEn && state_q == DNS_BOOT && !stored_q.extBaudEnable |=> !extBaudActive)
      else $error("extended rate without stored enable");
   a_ext_rate: assert property (@(posedge sys_clk) disable iff (sys_rst)
      clkEn && state_q == DNS_BOOT && extQualify
      |=> extBaudActive && baudActive == $past(stored_q.baudSel))
      else $error("qualified extended rate not applied");
   a_test_entry: assert property (@(posedge sys_clk) disable iff (sys_rst)
      clkEn && state_q != DNS_TEST && testFunctionSwitch |=> testActive)
      else $error("test switch did not enter test mode");

   c_test_entry: cover property (@(posedge sys_clk) state_q == DNS_RUN ##1 state_q == DNS_TEST);
   c_reject: cover property (@(posedge sys_clk) cfgReject);
   c_ext_baud: cover property (@(posedge sys_clk) extBaudActive && baudActive == DNS_B1M);
   c_error_clear: cover property (@(posedge sys_clk) errActive ##1 !errActive);

endmodule // dns_status_config

// ---- dns_net_model.sv ----
// Purpose: Network and host status source for the display block
// Assumes: Scenario control comes from the bench at falling edges
// Notes: One error at a time; idx 6 or 7 means no error
`timescale 1ns/100ps
module dns_net_model #(
   parameter logic [5:0] ADDR = 6'h2A
) (
   // Scenario control
   input wire logic [2:0] errIdx,
   input wire logic stopReq,
   // Status toward the block
   output dns_pkg::dns_err_t errIn,
   output logic plcStopped,
   output logic [5:0] nodeAddr
);
   import dns_pkg::*;
   // Combinational so the block sees changes with no extra edge
   wire logic [5:0] errBits = (errIdx < 3'h6) ? (6'h20 >> errIdx) : 6'h00;
   assign errIn = dns_err_t'(errBits);
   assign plcStopped = stopReq;
   assign nodeAddr = ADDR;
endmodule // dns_net_model

// ---- tb_top.sv ----
// Purpose: Self-checking bench of the status and configuration block
// Assumes: Inputs change at falling edges; display lags one cycle
// Notes: Power cycles are modelled by sys_rst
`timescale 1ns/100ps
module tb_top;
   import dns_pkg::*;
   localparam logic [5:0] ADDR = 6'h2A;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic clkEn = 1'b1;
   logic testSw = 1'b0;
   logic bLow = 1'b0;
   logic bHigh = 1'b0;
   logic cfgWrite = 1'b0;
   logic stopReq = 1'b0;
   logic [2:0] errIdx = 3'h7;
   dns_cfg_t cfgIn = '0;
   dns_err_t errIn;
   logic plcStopped, cfgReject, errActive, masterActive, extBaudActive, testActive;
   logic [5:0] nodeAddr;
   logic [7:0] dispCode, inSizeActive, outSizeActive;
   dns_baud_t baudActive;
   int errors = 0;
   int samples_checked = 0;
   always #10 sys_clk = ~sys_clk;
   dns_net_model #(.ADDR(ADDR)) dns_net_model_inst (.errIdx(errIdx), .stopReq(stopReq),
      .errIn(errIn), .plcStopped(plcStopped), .nodeAddr(nodeAddr));
   dns_status_config dns_status_config_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .clkEn(clkEn), .testFunctionSwitch(testSw), .baudSelectSwitchLow(bLow),
      .baudSelectSwitchHigh(bHigh), .errIn(errIn), .plcStopped(plcStopped),
      .nodeAddr(nodeAddr), .cfgWrite(cfgWrite), .cfgIn(cfgIn), .cfgReject(cfgReject),
      .dispCode(dispCode), .errActive(errActive), .masterActive(masterActive),
      .baudActive(baudActive), .extBaudActive(extBaudActive),
      .inSizeActive(inSizeActive), .outSizeActive(outSizeActive), .testActive(testActive));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic tick(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %0t %s", $time, msg);
      end
   endtask
   task automatic power_cycle();
      sys_rst = 1'b1;
      tick(2);
      sys_rst = 1'b0;
      tick(3);
   endtask
   task automatic dl(input dns_cfg_t c, input logic expRej);
      cfgIn = c;
      cfgWrite = 1'b1;
      tick(1);
      cfgWrite = 1'b0;
      chk(8'(cfgReject), 8'(expRej), "reject answer");
      tick(1);
      chk(8'(cfgReject), 8'h00, "reject is one pulse");
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_defaults();
      chk(8'(masterActive), 8'h00, "default role");
      chk(inSizeActive, 8'h08, "default in size");
      chk(outSizeActive, 8'h08, "default out size");
      chk(8'(baudActive), 8'h03, "default rate");
      chk(dispCode, {2'h0, ADDR}, "address shown");
   endtask
   task automatic t_errors();
      logic [7:0] want;
      for (int k = 0; k < 6; k++) begin
         errIdx = 3'(k);
         want = (k < 3) ? 8'hF0 + 8'(k) : 8'hF1 + 8'(k);
         tick(2);
         chk(dispCode, want, "error code");
         chk(8'(errActive), 8'h01, "error flag");
      end
      errIdx = 3'h7;
      stopReq = 1'b1;
      tick(2);
      chk(dispCode, 8'h80, "host stopped");
      chk(8'(errActive), 8'h00, "stop is not an error");
      errIdx = 3'h2;
      tick(2);
      chk(dispCode, 8'hF2, "error over stop");
      errIdx = 3'h7;
      stopReq = 1'b0;
      clkEn = 1'b0;
      tick(2);
      chk(dispCode, 8'hF2, "frozen without enable");
      clkEn = 1'b1;
      tick(2);
      chk(dispCode, {2'h0, ADDR}, "address back");
      chk(8'(errActive), 8'h00, "error flag cleared");
   endtask
   task automatic t_role();
      dl({1'b1, 1'b1, DNS_B1M, 8'hC8, 8'hC8}, 1'b0);
      chk(8'(masterActive), 8'h00, "role waits for power-on");
      dl({1'b0, 1'b0, DNS_B10K, 8'hC9, 8'h08}, 1'b1);
      dl({1'b0, 1'b0, DNS_B10K, 8'h08, 8'hC9}, 1'b1);
      bLow = 1'b1;
      bHigh = 1'b1;
      power_cycle();
      chk(8'(masterActive), 8'h01, "role after power-on");
      chk(inSizeActive, 8'hC8, "oversize not stored");
      chk(outSizeActive, 8'hC8, "max out size");
   endtask
   task automatic t_baud();
      logic [2:0] e;
      for (int b = 0; b < 8; b++) begin
         for (int m = 0; m < 3; m++) begin
            dl({1'b0, 1'b1, 3'(b), 8'h08, 8'h08}, 1'b0);
            bLow = (m != 0);
            bHigh = (m == 2);
            power_cycle();
            e = (m == 2 || (b >= 3 && b <= 5)) ? 3'(b) : 3'h3;
            chk(8'(baudActive), 8'(e), "active rate");
            chk(8'(extBaudActive), 8'(m == 2), "extended flag");
         end
      end
   endtask
   task automatic t_test();
      testSw = 1'b1;
      tick(2);
      chk(dispCode, 8'hF3, "test code");
      chk(8'(testActive), 8'h01, "test mode on");
      chk(8'(errActive), 8'h01, "test counts as error");
      power_cycle();
      chk(8'(testActive), 8'h01, "test kept while switch on");
      chk(dispCode, 8'hF3, "test code after power-on");
      testSw = 1'b0;
      tick(3);
      chk(dispCode, 8'hF3, "test kept without power cycle");
      power_cycle();
      chk(8'(testActive), 8'h00, "test left");
      chk(dispCode, {2'h0, ADDR}, "address after test");
   endtask
   initial begin
      repeat (5) @(posedge sys_clk);
      @(negedge sys_clk);
      sys_rst = 1'b0;
      tick(3);
      t_defaults();
      t_errors();
      t_role();
      t_baud();
      t_test();
      final_report();
   end
endmodule // tb_top
